// *** hl_pkg.sv ***
// hl_pkg: constants and carrier types for the hdlc link controller.
// assumes byte registers reached by word index over a 32-bit bus.
package hl_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [8:0] IDX_RX_MAP      = 9'h010;
  localparam logic [8:0] IDX_RX_SUPPRESS = 9'h011;
  localparam logic [8:0] IDX_RX_LEVEL    = 9'h087;
  localparam logic [8:0] IDX_RX_LATCH    = 9'h094;
  localparam logic [8:0] IDX_RX_MASK     = 9'h0a4;
  localparam logic [8:0] IDX_RX_LIVE     = 9'h0b4;
  localparam logic [8:0] IDX_RX_READY    = 9'h0b5;
  localparam logic [8:0] IDX_RX_PORT     = 9'h0b6;
  localparam logic [8:0] IDX_TX_MISC     = 9'h110;
  localparam logic [8:0] IDX_TX_SUPPRESS = 9'h111;
  localparam logic [8:0] IDX_TX_SLOT     = 9'h113;
  localparam logic [8:0] IDX_TX_LEVEL    = 9'h187;
  localparam logic [8:0] IDX_TX_LATCH    = 9'h191;
  localparam logic [8:0] IDX_TX_MASK     = 9'h1a1;
  localparam logic [8:0] IDX_TX_LIVE     = 9'h1b1;
  localparam logic [8:0] IDX_TX_SPACE    = 9'h1b3;
  localparam logic [8:0] IDX_TX_PORT     = 9'h1b4;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         MAP_MODE_HI    = 7;
  localparam int         MAP_MODE_LO    = 6;
  localparam logic [1:0] MODE_SLOT      = 2'h0;
  localparam logic [1:0] MODE_SPARE     = 2'h1;
  localparam logic [1:0] MODE_FACILITY  = 2'h2;
  localparam int         TXM_ENABLE     = 0;
  localparam int         TXM_LAST       = 1;
  localparam int         RXE_START      = 0;
  localparam int         RXE_HIGH       = 1;
  localparam int         RXE_END        = 2;
  localparam int         RXE_CRC        = 3;
  localparam int         RXE_ABORT      = 4;
  localparam int         RXE_OVERFLOW   = 5;
  localparam int         TXE_LOW        = 0;
  localparam int         TXE_UNDERRUN   = 1;
  localparam int         TXE_SENT       = 2;

  // ------------------------------------------------------------
  // fifo and framing constants
  // ------------------------------------------------------------
  localparam logic [6:0]  FIFO_DEPTH    = 7'h40;
  localparam logic [7:0]  FLAG_BYTE     = 8'h7e;
  localparam logic [7:0]  ABORT_BYTE    = 8'hff;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE   = 16'hf0b8;
  localparam logic [2:0]  STUFF_ONES    = 3'h5;
  localparam logic [2:0]  FLAG_ONES     = 3'h6;

  typedef struct packed {
    logic       en;     // one-cycle bit strobe from the framer
    logic [4:0] slot;   // time slot of this bit
    logic [2:0] pos;    // bit position, or spare bit number minus four
    logic       spare;  // bit is one of the e1 spare bits
    logic       facility_link_bits;    // bit is a t1 facility data link bit
  } hl_slot_t;

  typedef struct packed {
    logic       abrt;
    logic       bad;
    logic       eom;
    logic [7:0] data;
  } hl_rx_entry_t;

  typedef struct packed {
    logic       eom;
    logic [7:0] data;
  } hl_tx_entry_t;

  typedef enum logic [4:0] {
    TX_FLAG  = 5'b00001,
    TX_DATA  = 5'b00010,
    TX_FCS1  = 5'b00100,
    TX_FCS2  = 5'b01000,
    TX_ABORT = 5'b10000
  } hl_tx_state_t;

endpackage : hl_pkg

// *** hl_link_ctrl.sv ***
// hl_link_ctrl: hdlc controller with 64-byte receive and transmit fifos.
// assumes framer bit strobes on clk_i and an avalon-mm master on the bus.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - map onto slot, spare bits, or facility bits
// - separate 64-byte receive and transmit fifos
// - selectable bits in slot; others suppressed
// - flags, fcs, aborts, zero stuffing, byte alignment
// - level control registers set fifo watermarks
// - rx high flag live while above watermark
// - tx low flag live while below watermark
// - enabled watermark condition drives interrupt
// - overflow drops packet, empties fifo, reports
// - low seven bits give readable bytes
// - byte count stops at message end
// - msb set while message not yet ended
// - latched bit holds until one written
// - zeros and live bits unaffected by write
// - each latched event individually maskable
// - unmasked event pulls interrupt low
// - tx space live, stable during read
module hl_link_ctrl
  import hl_pkg::*;
(
  input  wire logic        clk_i,             // 25 MHz clock
  input  wire logic        arst_n_i,          // async reset, active low
  input  wire logic [8:0]  avs_address_i,     // register index
  input  wire logic        avs_read_i,        // read request
  input  wire logic        avs_write_i,       // write request
  input  wire logic [31:0] avs_writedata_i,   // write data
  input  wire logic [3:0]  avs_byteenable_i,  // byte enables
  output logic      [31:0] avs_readdata_o,    // read data
  output logic             avs_waitrequest_o, // stall
  input  wire hl_slot_t    rx_slot_i,         // receive bit timing
  input  wire logic        rx_data_i,         // receive bit
  input  wire hl_slot_t    tx_slot_i,         // transmit bit timing
  output logic             tx_data_o,         // transmit bit
  output logic             interrupt_out_n_o  // interrupt, active low
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [7:0]   rx_link_map_control, rx_bit_suppress, rx_fifo_level_control;
  logic [7:0]   rx_event_latch, rx_event_mask;
  logic [7:0]   tx_misc_control, tx_bit_suppress, tx_slot_select;
  logic [7:0]   tx_fifo_level_control, tx_event_latch, tx_event_mask;
  hl_rx_entry_t rx_mem [64];
  hl_tx_entry_t tx_mem [64];
  logic [6:0]   rx_wr, rx_rd, tx_wr, tx_rd;
  logic [6:0]   rx_fill, tx_fill, rb_cnt;
  logic         rb_end;
  logic         done, acc_wr, acc_rd, be0;
  logic         rx_pop, tx_push, rx_sel, tx_sel;
  logic         rx_high_level_flag, tx_low_level_flag, rx_high_q, tx_low_q;
  logic         rx_push, rx_first, rx_ovf_evt;
  hl_rx_entry_t rx_push_ent;
  logic         rx_in_frame, rx_drop, rx_started;
  logic [2:0]   rx_ones, rx_bits, rx_nheld;
  logic [7:0]   rx_byte;
  logic [7:0]   rx_held [3];
  logic [15:0]  rx_crc;
  logic         tx_pop, tx_last, tx_under_evt, tx_sent_evt;
  logic [2:0]   tx_ones, tx_bits;
  logic [7:0]   tx_sh, tx_fcs_hi;
  logic [15:0]  tx_crc;
  hl_tx_state_t tx_st;
  logic         tx_stuffing;
  logic [7:0]   rx_set, tx_set, rx_pend, tx_pend;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // bit belongs to the controller: mapping mode plus per-bit suppression in slot and spare modes
  function automatic logic bit_taken(input hl_slot_t s, input logic [7:0] map,
                                     input logic [7:0] supp);
    logic r;
    case (map[MAP_MODE_HI:MAP_MODE_LO])
      MODE_SLOT:     r = (s.slot == map[4:0]) && !s.spare && !s.facility_link_bits && !supp[s.pos];
      MODE_SPARE:    r = s.spare && !supp[s.pos];
      MODE_FACILITY: r = s.facility_link_bits;
      default:       r = 1'b0;
    endcase
    return s.en && r;
  endfunction

  assign rx_sel  = bit_taken(rx_slot_i, rx_link_map_control, rx_bit_suppress);
  assign tx_sel  = bit_taken(tx_slot_i, tx_slot_select, tx_bit_suppress);
  assign rx_fill = rx_wr - rx_rd;
  assign tx_fill = tx_wr - tx_rd;
  assign rx_high_level_flag = rx_fill > {1'b0, rx_fifo_level_control[5:0]};
  assign tx_low_level_flag  = tx_fill < {1'b0, tx_fifo_level_control[5:0]};
  assign tx_stuffing = (tx_st == TX_DATA) || (tx_st == TX_FCS1) || (tx_st == TX_FCS2);

  // ------------------------------------------------------------
  // avalon slave: one wait cycle, data captured in the first
  // ------------------------------------------------------------
  assign done   = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign acc_wr = done && avs_write_i;
  assign acc_rd = done && avs_read_i;
  assign be0    = avs_byteenable_i[0];
  assign rx_pop  = acc_rd && (avs_address_i == IDX_RX_PORT) && (rx_fill != 7'h00);
  assign tx_push = acc_wr && be0 && (avs_address_i == IDX_TX_PORT) && (tx_fill != FIFO_DEPTH);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_waitrequest_o <= 1'b1;
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  // count up to and including the first end-of-message entry
  always_comb
  begin
    rb_cnt = 7'h00;
    rb_end = 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      if ((7'(i) < rx_fill) && !rb_end)
      begin
        rb_cnt = rb_cnt + 7'h01;
        if (rx_mem[6'(rx_rd[5:0] + 6'(i))].eom)
          rb_end = 1'b1;
      end
    end
  end

  // read data is sampled in the wait cycle, so it is stable for the whole read
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && avs_waitrequest_o)
    begin
      case (avs_address_i)
        IDX_RX_MAP:      avs_readdata_o <= {24'h0, rx_link_map_control};
        IDX_RX_SUPPRESS: avs_readdata_o <= {24'h0, rx_bit_suppress};
        IDX_RX_LEVEL:    avs_readdata_o <= {24'h0, rx_fifo_level_control};
        IDX_RX_LATCH:    avs_readdata_o <= {24'h0, rx_event_latch};
        IDX_RX_MASK:     avs_readdata_o <= {24'h0, rx_event_mask};
        IDX_RX_LIVE:     avs_readdata_o <= {26'h0, rx_drop, 3'h0, rx_high_level_flag,
                                            rx_fill == 7'h00};
        IDX_RX_READY:    avs_readdata_o <= {24'h0, !rb_end && (rb_cnt != 7'h00), rb_cnt};
        IDX_RX_PORT:     avs_readdata_o <= {24'h0, rx_mem[rx_rd[5:0]].data};
        IDX_TX_MISC:     avs_readdata_o <= {24'h0, tx_misc_control};
        IDX_TX_SUPPRESS: avs_readdata_o <= {24'h0, tx_bit_suppress};
        IDX_TX_SLOT:     avs_readdata_o <= {24'h0, tx_slot_select};
        IDX_TX_LEVEL:    avs_readdata_o <= {24'h0, tx_fifo_level_control};
        IDX_TX_LATCH:    avs_readdata_o <= {24'h0, tx_event_latch};
        IDX_TX_MASK:     avs_readdata_o <= {24'h0, tx_event_mask};
        IDX_TX_LIVE:     avs_readdata_o <= {29'h0, !tx_st[0], tx_fill == FIFO_DEPTH,
                                            tx_low_level_flag};
        IDX_TX_SPACE:    avs_readdata_o <= {25'h0, FIFO_DEPTH - tx_fill};
        default:         avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_link_map_control   <= REG_RESET;
      rx_bit_suppress       <= REG_RESET;
      rx_fifo_level_control <= REG_RESET;
      rx_event_mask         <= REG_RESET;
      tx_misc_control       <= REG_RESET;
      tx_bit_suppress       <= REG_RESET;
      tx_slot_select        <= REG_RESET;
      tx_fifo_level_control <= REG_RESET;
      tx_event_mask         <= REG_RESET;
    end
    else if (acc_wr && be0)
    begin
      case (avs_address_i)
        IDX_RX_MAP:      rx_link_map_control   <= avs_writedata_i[7:0];
        IDX_RX_SUPPRESS: rx_bit_suppress       <= avs_writedata_i[7:0];
        IDX_RX_LEVEL:    rx_fifo_level_control <= avs_writedata_i[7:0];
        IDX_RX_MASK:     rx_event_mask         <= avs_writedata_i[7:0];
        IDX_TX_MISC:     tx_misc_control       <= avs_writedata_i[7:0];
        IDX_TX_SUPPRESS: tx_bit_suppress       <= avs_writedata_i[7:0];
        IDX_TX_SLOT:     tx_slot_select        <= avs_writedata_i[7:0];
        IDX_TX_LEVEL:    tx_fifo_level_control <= avs_writedata_i[7:0];
        IDX_TX_MASK:     tx_event_mask         <= avs_writedata_i[7:0];
        IDX_TX_PORT:     tx_misc_control[TXM_LAST] <= 1'b0; // last marker is one-shot
        default:         tx_misc_control       <= tx_misc_control;
      endcase
    end
  end

  // ------------------------------------------------------------
  // latched events: set wins over a write-one clear
  // ------------------------------------------------------------
  assign rx_set = {2'h0, rx_ovf_evt,
                   rx_pop && rx_mem[rx_rd[5:0]].abrt,
                   rx_pop && rx_mem[rx_rd[5:0]].bad && !rx_mem[rx_rd[5:0]].abrt,
                   rx_pop && rx_mem[rx_rd[5:0]].eom,
                   rx_high_level_flag && !rx_high_q,
                   rx_push && rx_first};
  assign tx_set = {5'h0, tx_sent_evt, tx_under_evt, tx_low_level_flag && !tx_low_q};

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_event_latch <= REG_RESET;
      tx_event_latch <= REG_RESET;
      rx_pend        <= REG_RESET;
      tx_pend        <= REG_RESET;
      rx_high_q      <= 1'b0;
      tx_low_q       <= 1'b0;
    end
    else
    begin
      rx_high_q <= rx_high_level_flag;
      tx_low_q  <= tx_low_level_flag;
      rx_event_latch <= (rx_event_latch & ~((acc_wr && be0 && avs_address_i == IDX_RX_LATCH)
                         ? avs_writedata_i[7:0] : 8'h00)) | rx_set;
      tx_event_latch <= (tx_event_latch & ~((acc_wr && be0 && avs_address_i == IDX_TX_LATCH)
                         ? avs_writedata_i[7:0] : 8'h00)) | tx_set;
      // pending bits drop when the latch is captured for a read
      rx_pend <= ((avs_read_i && avs_waitrequest_o && avs_address_i == IDX_RX_LATCH)
                  ? 8'h00 : rx_pend) | rx_set;
      tx_pend <= ((avs_read_i && avs_waitrequest_o && avs_address_i == IDX_TX_LATCH)
                  ? 8'h00 : tx_pend) | tx_set;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      interrupt_out_n_o <= 1'b1;
    else
      interrupt_out_n_o <= !(|(rx_pend & rx_event_latch & rx_event_mask)
                           || |(tx_pend & tx_event_latch & tx_event_mask)
                           || (rx_high_level_flag && rx_event_mask[RXE_HIGH])
                           || (tx_low_level_flag && tx_event_mask[TXE_LOW]));
  end

  // ------------------------------------------------------------
  // fifo pointers and storage
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_wr      <= 7'h00;
      rx_rd      <= 7'h00;
      rx_ovf_evt <= 1'b0;
    end
    else
    begin
      rx_ovf_evt <= 1'b0;
      if (rx_push && (rx_fill == FIFO_DEPTH))
      begin
        rx_wr      <= 7'h00;
        rx_rd      <= 7'h00;
        rx_ovf_evt <= 1'b1;
      end
      else
      begin
        if (rx_push)
          rx_wr <= rx_wr + 7'h01;
        if (rx_pop)
          rx_rd <= rx_rd + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rx_push && (rx_fill != FIFO_DEPTH))
      rx_mem[rx_wr[5:0]] <= rx_push_ent;
    if (tx_push)
      tx_mem[tx_wr[5:0]] <= '{eom: tx_misc_control[TXM_LAST], data: avs_writedata_i[7:0]};
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_wr <= 7'h00;
      tx_rd <= 7'h00;
    end
    else
    begin
      if (tx_push)
        tx_wr <= tx_wr + 7'h01;
      if (tx_pop)
        tx_rd <= tx_rd + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // receive engine: flag hunt, destuff, three-byte fcs delay
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_in_frame <= 1'b0;
      rx_drop     <= 1'b0;
      rx_started  <= 1'b0;
      rx_ones     <= 3'h0;
      rx_bits     <= 3'h0;
      rx_nheld    <= 3'h0;
      rx_byte     <= 8'h00;
      rx_held     <= '{default: 8'h00};
      rx_crc      <= CRC_INIT;
      rx_push     <= 1'b0;
      rx_first    <= 1'b0;
      rx_push_ent <= '0;
    end
    else
    begin
      rx_push  <= 1'b0;
      rx_first <= 1'b0;
      if (rx_ovf_evt)
        rx_drop <= 1'b1;
      if (rx_sel)
      begin
        rx_ones <= rx_data_i ? ((rx_ones == 3'h7) ? rx_ones : rx_ones + 3'h1) : 3'h0;
        if (rx_data_i && (rx_ones == FLAG_ONES))
        begin
          if (rx_in_frame && rx_nheld != 3'h0 && !rx_drop)
          begin
            rx_push     <= 1'b1;
            rx_first    <= !rx_started;
            rx_push_ent <= '{abrt: 1'b1, bad: 1'b1, eom: 1'b1, data: rx_held[0]};
          end
          rx_in_frame <= 1'b0;
        end
        else if (!rx_data_i && (rx_ones == FLAG_ONES))
        begin
          if (rx_in_frame && rx_nheld != 3'h0 && !rx_drop)
          begin
            rx_push     <= 1'b1;
            rx_first    <= !rx_started;
            rx_push_ent <= '{abrt: 1'b0, eom: 1'b1, data: rx_held[0],
                             bad: !((rx_bits == 3'h7) && (rx_nheld == 3'h3)
                                    && (rx_crc == CRC_RESIDUE))};
          end
          rx_in_frame <= 1'b1;
          rx_drop     <= 1'b0;
          rx_started  <= 1'b0;
          rx_bits     <= 3'h0;
          rx_nheld    <= 3'h0;
          rx_crc      <= CRC_INIT;
        end
        else if (!(!rx_data_i && (rx_ones == STUFF_ONES)) && rx_in_frame)
        begin
          rx_byte <= {rx_data_i, rx_byte[7:1]};
          rx_bits <= rx_bits + 3'h1;
          if (rx_bits == 3'h7)
          begin
            rx_crc     <= crc_byte(rx_crc, {rx_data_i, rx_byte[7:1]});
            rx_held[0] <= rx_held[1];
            rx_held[1] <= rx_held[2];
            rx_held[2] <= {rx_data_i, rx_byte[7:1]};
            if (rx_nheld == 3'h3)
            begin
              if (!rx_drop)
              begin
                rx_push     <= 1'b1;
                rx_first    <= !rx_started;
                rx_started  <= 1'b1;
                rx_push_ent <= '{abrt: 1'b0, bad: 1'b0, eom: 1'b0, data: rx_held[0]};
              end
            end
            else
              rx_nheld <= rx_nheld + 3'h1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // transmit engine: flags when idle, stuffing, fcs, abort
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_st        <= TX_FLAG;
      tx_sh        <= FLAG_BYTE;
      tx_bits      <= 3'h0;
      tx_ones      <= 3'h0;
      tx_crc       <= CRC_INIT;
      tx_fcs_hi    <= 8'h00;
      tx_last      <= 1'b0;
      tx_pop       <= 1'b0;
      tx_under_evt <= 1'b0;
      tx_sent_evt  <= 1'b0;
      tx_data_o    <= 1'b1;
    end
    else
    begin
      tx_pop       <= 1'b0;
      tx_under_evt <= 1'b0;
      tx_sent_evt  <= 1'b0;
      if (tx_sel && !tx_pop)
      begin
        if (tx_stuffing && (tx_ones == STUFF_ONES))
        begin
          tx_data_o <= 1'b0;
          tx_ones   <= 3'h0;
        end
        else
        begin
          tx_data_o <= tx_sh[0];
          tx_ones   <= (tx_stuffing && tx_sh[0]) ? tx_ones + 3'h1 : 3'h0;
          tx_sh     <= {1'b0, tx_sh[7:1]};
          tx_bits   <= tx_bits + 3'h1;
          if (tx_bits == 3'h7)
          begin
            case (tx_st)
              TX_FLAG:
              begin
                if (tx_misc_control[TXM_ENABLE] && (tx_fill != 7'h00))
                begin
                  tx_pop  <= 1'b1;
                  tx_sh   <= tx_mem[tx_rd[5:0]].data;
                  tx_last <= tx_mem[tx_rd[5:0]].eom;
                  tx_crc  <= crc_byte(CRC_INIT, tx_mem[tx_rd[5:0]].data);
                  tx_st   <= TX_DATA;
                end
                else
                  tx_sh <= FLAG_BYTE;
              end
              TX_DATA:
              begin
                if (tx_last)
                begin
                  tx_sh     <= ~tx_crc[7:0];
                  tx_fcs_hi <= ~tx_crc[15:8];
                  tx_st     <= TX_FCS1;
                end
                else if (tx_fill == 7'h00)
                begin
                  tx_sh        <= ABORT_BYTE;
                  tx_under_evt <= 1'b1;
                  tx_st        <= TX_ABORT;
                end
                else
                begin
                  tx_pop  <= 1'b1;
                  tx_sh   <= tx_mem[tx_rd[5:0]].data;
                  tx_last <= tx_mem[tx_rd[5:0]].eom;
                  tx_crc  <= crc_byte(tx_crc, tx_mem[tx_rd[5:0]].data);
                end
              end
              TX_FCS1:
              begin
                tx_sh <= tx_fcs_hi;
                tx_st <= TX_FCS2;
              end
              TX_FCS2:
              begin
                tx_sh       <= FLAG_BYTE;
                tx_sent_evt <= 1'b1;
                tx_st       <= TX_FLAG;
              end
              default:
              begin
                tx_sh <= FLAG_BYTE;
                tx_st <= TX_FLAG;
              end
            endcase
          end
        end
      end
    end
  end

endmodule : hl_link_ctrl

`default_nettype wire

// *** hl_link_ctrl_assertions.sv ***
// port checks for the hdlc link controller.
// assumes one clock and a bus answering after one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module hl_chk
  import hl_pkg::*;
(
  input wire logic        clk_i,             // clock
  input wire logic        arst_n_i,          // reset
  input wire logic [8:0]  avs_address_i,     // index
  input wire logic        avs_read_i,        // read
  input wire logic        avs_write_i,       // write
  input wire logic [31:0] avs_readdata_o,    // data
  input wire logic        avs_waitrequest_o, // stall
  input wire hl_slot_t    tx_slot_i,         // tx strobe
  input wire logic        tx_data_o,         // tx bit
  input wire logic        interrupt_out_n_o  // irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire ok = avs_read_i && !avs_waitrequest_o;
  wire rr = ok && avs_address_i == IDX_RX_READY;
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no answer");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("long");
  a_upper_zero: assert property (ok |-> avs_readdata_o[31:8] == 24'h0) else $error("upper");
  a_ready_max: assert property (rr |-> avs_readdata_o[6:0] <= 7'h40) else $error("count");
  a_ready_msb: assert property (rr && avs_readdata_o[7] |-> avs_readdata_o[6:0] != 7'h0)
    else $error("msb");
  a_data_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("hold");
  a_tx_strobe: assert property ($changed(tx_data_o) |-> $past(tx_slot_i.en)
    || $past(tx_slot_i.en, 2)) else $error("tx bit");
  a_int_reset: assert property (!$past(arst_n_i) |-> interrupt_out_n_o) else $error("irq");
  c_ready_open: cover property (rr && avs_readdata_o[7]);
  c_int_low: cover property (!interrupt_out_n_o);
  c_tx_bit: cover property ($changed(tx_data_o));
endmodule // hl_chk
bind hl_link_ctrl hl_chk i_chk (.*);
`default_nettype wire

// *** hl_framer_model.sv ***
// framer model: bit strobes on slot 3 and the receive bit stream.
// assumes the bench queues frame bits through send; idles on flags.
`timescale 1ns/1ps
`default_nettype none
module hl_frm
  import hl_pkg::*;
(
  input  wire logic clk_i,     // clock
  output hl_slot_t  rx_slot_o, // rx strobe
  output logic      rx_data_o, // rx bit
  output hl_slot_t  tx_slot_o  // tx strobe
);
  logic       q[$];
  logic [2:0] ph = 3'h0;
  logic [2:0] pc = 3'h0;
  int         ones = 0;
  assign rx_slot_o = {ph == 3'h0, 5'h03, pc, 2'h0};
  assign tx_slot_o = {ph == 3'h4, 5'h03, pc, 2'h0};
  task automatic send(input logic [7:0] d, input logic raw);
    for (int i = 0; i < 8; i++)
    begin
      q.push_back(d[i]);
      ones = (raw || !d[i]) ? 0 : ones + 1;
      if (ones == 5)
      begin
        q.push_back(1'b0);
        ones = 0;
      end
    end
  endtask
  always @(posedge clk_i)
  begin
    ph <= ph + 3'h1;
    if (ph == 3'h0)
      pc <= pc + 3'h1;
    if (q.size() == 0)
      send(FLAG_BYTE, 1'b1);
    if (ph == 3'h7)
      rx_data_o <= q.pop_front();
    else
      rx_data_o <= ~rx_data_o;
  end
endmodule // hl_frm
`default_nettype wire

// *** hl_link_ctrl_bench.sv ***
// register-level tests of the hdlc link controller.
// assumes the framer model supplies strobes and receive bits.
`timescale 1ns/1ps
`default_nettype none
module hl_link_ctrl_bench
  import hl_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [8:0]  avs_address_i = 9'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  hl_slot_t    rx_slot_i;
  hl_slot_t    tx_slot_i;
  logic        rx_data_i;
  logic        tx_data_o;
  logic        interrupt_out_n_o;
  logic [7:0]  q;
  logic [15:0] crc;
  int          errors = 0;
  int          tests_run = 0;
  hl_link_ctrl i_dut (.*, .avs_byteenable_i(4'h1));
  hl_frm i_frm (.clk_i(clk_i), .rx_slot_o(rx_slot_i), .rx_data_o(rx_data_i), .tx_slot_o(tx_slot_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic end_of_test;
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e, input string n);
    acc(1'b0, a, 8'h0);
    chk(q, e, n);
  endtask
  function automatic logic [15:0] upd(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(IDX_TX_MASK, REG_RESET, "tx mask");
    rd(IDX_TX_SPACE, 8'h40, "tx space");
    rd(IDX_RX_READY, 8'h00, "rx ready");
    rd(9'h000, 8'h00, "unmapped");
    acc(1'b1, IDX_RX_MAP, 8'h03);
    acc(1'b1, IDX_RX_LEVEL, 8'h3f);
    acc(1'b1, IDX_RX_MASK, 8'h01);
    crc = CRC_INIT;
    i_frm.send(FLAG_BYTE, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      q = (i == 0) ? 8'hff : (i == 1) ? FLAG_BYTE : (i == 2) ? ~crc[7:0] : ~crc[15:8];
      i_frm.send(q, 1'b0);
      if (i < 2)
        crc = upd(crc, q);
    end
    i_frm.send(FLAG_BYTE, 1'b1);
    wait (interrupt_out_n_o === 1'b0);
    rd(IDX_RX_READY, 8'h81, "rx ready open");
    do acc(1'b0, IDX_RX_READY, 8'h0); while (q[7] !== 1'b0);
    chk(q, 8'h02, "rx ready end");
    rd(IDX_RX_PORT, 8'hff, "rx byte");
    rd(IDX_RX_PORT, FLAG_BYTE, "rx byte");
    rd(IDX_RX_LATCH, 8'h05, "rx latch");
    rd(IDX_RX_LIVE, 8'h01, "rx live");
    chk({7'h0, interrupt_out_n_o}, 8'h01, "interrupt");
    acc(1'b1, IDX_RX_LATCH, 8'h01);
    rd(IDX_RX_LATCH, 8'h04, "rx latch");
    acc(1'b1, IDX_TX_SLOT, 8'h03);
    @(posedge tx_data_o);
    repeat (4) @(posedge clk_i);
    repeat (8)
    begin
      q = {tx_data_o, q[7:1]};
      repeat (8) @(posedge clk_i);
    end
    chk(q, 8'h3f, "tx flag");
    acc(1'b1, IDX_TX_PORT, 8'h12);
    acc(1'b1, IDX_TX_PORT, 8'h34);
    rd(IDX_TX_SPACE, 8'h3e, "tx space");
    acc(1'b1, IDX_TX_LEVEL, 8'h05);
    rd(IDX_TX_LIVE, 8'h01, "tx live");
    end_of_test;
  end
endmodule // hl_link_ctrl_bench
`default_nettype wire
